/* File: rtl/fpvs_defines.vh */
// Constants for the flash program/erase host sequencer.
// Assumes a 25 MHz mclk; included by bare name.
`ifndef FPVS_DEFINES_VH
`define FPVS_DEFINES_VH
`define FPVS_CLK_MHZ        25
`define FPVS_CMD_READ       8'h00
`define FPVS_CMD_ERASE      8'h20
`define FPVS_CMD_PROG_SETUP 8'h40
`define FPVS_CMD_ERASE_VFY  8'hA0
`define FPVS_CMD_PROG_VFY   8'hC0
`define FPVS_CMD_RESET      8'hFF
`define FPVS_ERASED_BYTE    8'hFF
// Times in their own units
`define FPVS_T_SUPPLY_NS    100
`define FPVS_T_PULSE_US     10
`define FPVS_T_RECOVER_US   6
`define FPVS_T_ERASE_MS     10
// Cycle counts; least times round up
`define FPVS_SUPPLY_CYC     ((`FPVS_T_SUPPLY_NS * `FPVS_CLK_MHZ + 999) / 1000)
`define FPVS_PULSE_CYC      (`FPVS_T_PULSE_US * `FPVS_CLK_MHZ)
`define FPVS_RECOVER_CYC    (`FPVS_T_RECOVER_US * `FPVS_CLK_MHZ)
`define FPVS_ERASE_CYC      (`FPVS_T_ERASE_MS * 1000 * `FPVS_CLK_MHZ)
`define FPVS_MAX_PULSES     25
`define FPVS_MAX_ERASE      1000
// Strobe low width in cycles; the high phase runs FPVS_WE_HIGH_CYC + 1 cycles
`define FPVS_WE_LOW_CYC     4
`define FPVS_WE_HIGH_CYC    2
`endif

/* File: rtl/fpvs_delay.v */
// Down-counting delay timer for the sequencer.
// Assumes start is a one-cycle pulse from logic on mclk.
`timescale 1ns/10ps
`default_nettype none
module fpvs_delay #(
	parameter W = 20
) (
	input  wire         mclk,
	input  wire         reset,
	input  wire         start,
	input  wire [W-1:0] count,
	output reg          done
);
	reg [W-1:0] cnt_q;
	reg         run_q;

	// Load on start, pulse done when expired
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_q <= {W{1'b0}};
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= count;
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/fpvs_seq.v */
// Host sequencer that programs or bulk-erases a parallel flash by its pins.
// Assumes program supply is switched on by this block and flash pins are pads.
// Function
// R1: Write C0h to verify; its strobe rising edge ends the programming pulse.
// R2: Device verifies last programmed byte, with the latched address; no new data.
// R3: Device returns margin-checked data on an ordinary read in verify state.
// R4: Keep intended byte; match advances, mismatch repeats setup, program, verify.
// R5: At most 25 programming pulses per byte per cycle.
// R6: Program needs two writes; setup 40h leaves array unchanged.
// R7: Second write: address at strobe fall, data at rise, pulse starts at rise.
// R8: Wait 10 us from program write rise before issuing verify.
// R9: Device stop timer ends each programming pulse after 10 us.
// R10: Wait at least 6 us after verify write before reading.
// R11: Reads during write recovery are invalid and may falsely fail.
// R12: Reset FFh returns to read mode; written at sequence end.
// R13: Program verify only after programming; optional final read-compare.
// R14: Time each erase pulse 10 ms; write erase-verify after each pulse.
// R15: End program or erase when timer expires or on interrupt.
// R16: Wait 100 ns after supply settles before any command.
// R17: Parallel erase verifies each device; mask done devices with 00h.
// R18: Device powers up in read mode, no command pending.
// R19: After setup 40h, write FFh twice; second aborts to read mode.
// R20: After any other command, one reset aborts and returns to read.
// R21: FFh data programs nothing; reset never alters array.
// R22: Host may always write reset twice.
// R23: Device programs only on write right after program setup.
// R24: Erase is two 20h writes; second rise starts whole-array erase.
// R25: Erase-verify A0h ends erase pulse; address latched at strobe fall.
// R26: Count pulses per byte; report failure after the maximum.
`timescale 1ns/10ps
`default_nettype none
`include "fpvs_defines.vh"
module fpvs_seq #(
	parameter AW         = 17,
	parameter ERASE_CYC  = `FPVS_ERASE_CYC,
	parameter MAX_ERASE  = `FPVS_MAX_ERASE
) (
	input  wire          mclk,
	input  wire          reset,
	input  wire          start_prog,
	input  wire          start_erase,
	input  wire          abort,
	input  wire [AW-1:0] user_addr,
	input  wire [7:0]    user_data,
	input  wire [AW-1:0] erase_last,
	output reg           busy,
	output reg           done,
	output reg           fail,
	output reg  [AW-1:0] fl_addr,
	output reg  [7:0]    fl_dq_out,
	output reg           fl_dq_oe_n,
	input  wire [7:0]    fl_dq_in,
	output reg           fl_ce_n,
	output reg           fl_oe_n,
	output reg           fl_we_n,
	output reg           program_supply_high
);
	localparam [3:0] S_IDLE = 4'h0, S_RAMP = 4'h1, S_WRITE = 4'h2, S_WAIT = 4'h3,
		S_READ = 4'h4, S_CHECK = 4'h5, S_DONE = 4'h6;
	// What follows the current write
	localparam [2:0] N_SETUP = 3'h0, N_PULSE = 3'h1, N_VFY = 3'h2, N_RST1 = 3'h3,
		N_RST2 = 3'h4, N_ERASE2 = 3'h5, N_MASK = 3'h6;
	// Counts held as full words, cut to each counter's width where used
	localparam [31:0] SUPPLY_W = `FPVS_SUPPLY_CYC;
	localparam [31:0] PULSE_W  = `FPVS_PULSE_CYC;
	localparam [31:0] RECOV_W  = `FPVS_RECOVER_CYC;
	localparam [31:0] ERASE_W  = ERASE_CYC;
	localparam [31:0] MAXE_W   = MAX_ERASE;
	localparam [31:0] MAXP_W   = `FPVS_MAX_PULSES;
	localparam [31:0] WELO_W   = `FPVS_WE_LOW_CYC;
	localparam [31:0] PH_W     = `FPVS_WE_LOW_CYC + `FPVS_WE_HIGH_CYC;
	localparam [3:0]  PH_MAX   = PH_W[3:0];

	reg [3:0]    state_q;
	reg [2:0]    step_q;
	reg          erase_q;
	reg [7:0]    cmd_q;
	reg [7:0]    want_q;
	reg [3:0]    ph_q;
	reg [4:0]    pulses_q;
	reg [9:0]    epulses_q;
	reg          err_q;
	reg [7:0]    rd_s1_q;
	reg [7:0]    rd_s2_q;
	reg          tstart_q;
	reg [23:0]   tcount_q;
	wire         tdone;

	fpvs_delay #(.W(24)) u_delay (
		.mclk  (mclk),
		.reset (reset),
		.start (tstart_q),
		.count (tcount_q),
		.done  (tdone)
	);

	// Two-stage sync of flash data pins
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_s1_q <= 8'h00;
			rd_s2_q <= 8'h00;
		end else begin
			rd_s1_q <= fl_dq_in;
			rd_s2_q <= rd_s1_q;
		end
	end

	// Main sequencer
	always @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= S_IDLE;
			step_q <= N_SETUP;
			erase_q <= 1'b0;
			cmd_q <= 8'h00;
			want_q <= 8'h00;
			ph_q <= 4'h0;
			pulses_q <= 5'h00;
			epulses_q <= 10'h000;
			err_q <= 1'b0;
			tstart_q <= 1'b0;
			tcount_q <= 24'h000000;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			fl_addr <= {AW{1'b0}};
			fl_dq_out <= 8'h00;
			fl_dq_oe_n <= 1'b1;
			fl_ce_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_we_n <= 1'b1;
			program_supply_high <= 1'b0;
		end else begin
			tstart_q <= 1'b0;
			done <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (start_prog || start_erase) begin
					erase_q <= start_erase;
					fl_addr <= start_erase ? {AW{1'b0}} : user_addr;
					want_q <= start_erase ? `FPVS_ERASED_BYTE : user_data;
					pulses_q <= 5'h00;
					epulses_q <= 10'h000;
					err_q <= 1'b0;
					busy <= 1'b1;
					fail <= 1'b0;
					fl_ce_n <= 1'b0;
					program_supply_high <= 1'b1;
					tcount_q <= SUPPLY_W[23:0];
					tstart_q <= 1'b1; // R16
					state_q <= S_RAMP;
				end
			end
			S_RAMP: begin
				if (tdone) begin
					cmd_q <= erase_q ? `FPVS_CMD_ERASE : `FPVS_CMD_PROG_SETUP; // R6 R24
					step_q <= erase_q ? N_ERASE2 : N_SETUP;
					ph_q <= 4'h0;
					state_q <= S_WRITE;
				end
			end
			S_WRITE: begin
				// Strobe low then high; device takes data at the rise
				ph_q <= ph_q + 4'h1;
				fl_dq_out <= cmd_q;
				fl_dq_oe_n <= 1'b0;
				fl_oe_n <= 1'b1;
				fl_we_n <= (ph_q < WELO_W[3:0]) ? 1'b0 : 1'b1;
				if (ph_q == PH_MAX) begin
					fl_dq_oe_n <= 1'b1;
					ph_q <= 4'h0;
					case (step_q)
					N_SETUP: begin
						cmd_q <= want_q; // R7 R23
						step_q <= N_PULSE;
						pulses_q <= pulses_q + 5'h01;
					end
					N_PULSE: begin
						tcount_q <= PULSE_W[23:0]; // R8
						tstart_q <= 1'b1;
						state_q <= S_WAIT;
					end
					N_ERASE2: begin
						// First 20h is setup; second starts erase
						if (pulses_q[0]) begin
							tcount_q <= ERASE_W[23:0]; // R14
							tstart_q <= 1'b1;
							epulses_q <= epulses_q + 10'h001;
							pulses_q <= 5'h00;
							state_q <= S_WAIT;
							step_q <= N_PULSE;
						end else begin
							pulses_q <= 5'h01;
						end
					end
					N_VFY: begin
						tcount_q <= RECOV_W[23:0]; // R10 R11
						tstart_q <= 1'b1;
						step_q <= N_VFY;
						state_q <= S_WAIT;
					end
					N_RST1: begin
						step_q <= N_RST2; // R19 R22
					end
					N_MASK: begin
						cmd_q <= `FPVS_CMD_RESET; // R17
						step_q <= N_RST1;
					end
					default: begin
						state_q <= S_DONE; // R12
					end
					endcase
				end
			end
			S_WAIT: begin
				if (abort && step_q == N_PULSE) begin
					cmd_q <= erase_q ? `FPVS_CMD_ERASE_VFY : `FPVS_CMD_PROG_VFY; // R15
					err_q <= 1'b1;
					step_q <= N_VFY;
					state_q <= S_WRITE;
				end else if (tdone && !tstart_q) begin // Stale expiry of an aborted pulse ignored
					if (step_q == N_PULSE) begin
						// Verify write ends the pulse
						cmd_q <= erase_q ? `FPVS_CMD_ERASE_VFY : `FPVS_CMD_PROG_VFY; // R1 R13 R25
						step_q <= N_VFY;
						state_q <= S_WRITE;
					end else begin
						state_q <= S_READ;
					end
				end
			end
			S_READ: begin
				// Ordinary read of margin data
				ph_q <= ph_q + 4'h1;
				fl_oe_n <= 1'b0; // R2 R3
				if (ph_q == PH_MAX) begin
					fl_oe_n <= 1'b1;
					ph_q <= 4'h0;
					state_q <= S_CHECK;
				end
			end
			S_CHECK: begin
				state_q <= S_WRITE;
				cmd_q <= `FPVS_CMD_RESET;
				step_q <= N_RST1;
				if (err_q) begin
					fail <= 1'b1;
				end else if (rd_s2_q == want_q) begin
					if (erase_q && fl_addr != erase_last) begin
						fl_addr <= fl_addr + {{(AW-1){1'b0}}, 1'b1};
						cmd_q <= `FPVS_CMD_ERASE_VFY;
						step_q <= N_VFY;
					end else if (erase_q) begin
						cmd_q <= `FPVS_CMD_READ; // R17
						step_q <= N_MASK;
					end
				end else if (!erase_q && pulses_q < MAXP_W[4:0]) begin
					cmd_q <= `FPVS_CMD_PROG_SETUP; // R4 R5
					step_q <= N_SETUP;
				end else if (erase_q && epulses_q < MAXE_W[9:0]) begin
					cmd_q <= `FPVS_CMD_ERASE; // Resume at failed address
					step_q <= N_ERASE2;
					pulses_q <= 5'h00;
				end else begin
					fail <= 1'b1; // R26
				end
			end
			S_DONE: begin
				busy <= 1'b0;
				done <= 1'b1;
				fl_ce_n <= 1'b1;
				program_supply_high <= 1'b0;
				state_q <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verification/fpvs_flash_model.sv */
// Behavioural flash on the sequencer's pins; 16 bytes kept.
// Assumes strobes from fpvs_seq; weak pulse counts set by the bench.
`timescale 1ns/10ps
`default_nettype none
module fpvs_flash_model (
	input wire logic        fl_ce_n,
	input wire logic        fl_oe_n,
	input wire logic        fl_we_n,
	input wire logic        fl_dq_oe_n,
	input wire logic        program_supply_high,
	input wire logic [16:0] fl_addr,
	input wire logic [7:0]  fl_dq_out,
	input wire logic [7:0]  pf,
	input wire logic [7:0]  ef,
	output logic     [7:0]  fl_dq_in,
	output int              np,
	output logic     [2:0]  mode = 3'h0
);
	logic [7:0] mem [16] = '{default: 8'hFF};
	logic [7:0] rd = 8'h00;
	logic [7:0] pd;
	logic [3:0] la, va;
	realtime    tv = 0;
	int         nall = 0, nbase = 0, nmask = 0;
	// Released bus shows the inverse of the last read
	assign fl_dq_in = !fl_dq_oe_n ? fl_dq_out : !fl_ce_n && !fl_oe_n ? rd : ~rd;
	// Program and erase-start strobes counted from the start of each job
	assign np = nall - nbase;
	always @(posedge program_supply_high) nbase = nall;
	// Read data fixed at output enable; early reads corrupted
	always @(negedge fl_oe_n)
		rd = (mode ? mem[va] : mem[fl_addr[3:0]]) ^ {8{mode && $realtime - tv < 6000}};
	always @(negedge fl_we_n) la = fl_addr[3:0];
	// Command decode at strobe rise
	always @(posedge fl_we_n) begin
		if (mode == 3'h1) begin
			mode = 3'h2;
			pd = fl_dq_in;
			va = la;
			nall++;
		end else if (fl_dq_in == 8'h40)
			mode = 3'h1;
		else if (fl_dq_in == 8'h20) begin
			nall += (mode == 3'h4);
			mode = mode == 3'h4 ? 3'h5 : 3'h4;
		end else if (fl_dq_in == 8'hC0 && mode == 3'h2) begin
			if (np > pf) mem[va] &= pd;
			mode = 3'h3;
			tv = $realtime;
		end else if (fl_dq_in == 8'hA0 && mode > 3'h4) begin
			if (mode == 3'h5 && np > ef) mem = '{default: 8'hFF};
			mode = 3'h6;
			va = la;
			tv = $realtime;
		end else begin
			nmask += (fl_dq_in == 8'h00 && mode == 3'h6);
			mode = 3'h0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/fpvs_seq_checker.sv */
// Assertions on the sequencer's flash pins and job status.
// Assumes binding onto fpvs_seq; one clock, async reset.
`timescale 1ns/10ps
`default_nettype none
module fpvs_seq_checker (
	input wire logic       mclk,
	input wire logic       reset,
	input wire logic       abort,
	input wire logic       done,
	input wire logic       fail,
	input wire logic       fl_we_n,
	input wire logic       fl_oe_n,
	input wire logic       fl_dq_oe_n,
	input wire logic       program_supply_high,
	input wire logic [7:0] fl_dq_out
);
	logic [15:0] gap_q;
	logic [4:0]  np_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Cycles since last strobe rise; setup writes per job
	always @(posedge mclk or posedge reset)
		if (reset) begin
			gap_q <= 16'h0000;
			np_q <= 5'h00;
		end else begin
			gap_q <= $rose(fl_we_n) ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF}; // Saturates
			np_q <= done ? 5'h00 : np_q + {4'h0, $rose(fl_we_n) && fl_dq_out == 8'h40};
		end
	we_width_a: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n)
		else $error("strobe width");
	data_hold_a: assert property (!fl_we_n && $past(!fl_we_n) |-> $stable(fl_dq_out) && !fl_dq_oe_n)
		else $error("data moved");
	supply_on_a: assert property (!fl_we_n |-> program_supply_high)
		else $error("no supply");
	bus_clash_a: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
		else $error("bus clash");
	verify_wait_a: assert property ($rose(fl_we_n) && fl_dq_out == 8'hC0 && !abort |-> gap_q >= 16'h00F9)
		else $error("verify early");
	recover_wait_a: assert property ($fell(fl_oe_n) |-> gap_q >= 16'h0095)
		else $error("read early");
	pulse_limit_a: assert property (np_q <= 5'h19)
		else $error("too many pulses");
	fail_done_a: assert property ($rose(fail) |-> ##[0:300] done)
		else $error("no done");
	cover property ($rose(fail));
	cover property (done && !fail);
	cover property ($rose(fl_we_n) && fl_dq_out == 8'hA0);
	cover property ($rose(fl_we_n) && fl_dq_out == 8'h00);
endmodule
bind fpvs_seq fpvs_seq_checker chk (.mclk, .reset, .abort, .done, .fail, .fl_we_n, .fl_oe_n, .fl_dq_oe_n,
	.program_supply_high, .fl_dq_out);
`default_nettype wire

/* File: verification/fpvs_seq_test.sv */
// Self-checking bench for fpvs_seq with the flash model.
// Assumes a shortened erase time; each job but the one reset in t_reset awaited on done.
`timescale 1ns/10ps
`default_nettype none
module fpvs_seq_test;
	logic        mclk = 1'b0, reset = 1'b1, start_prog = 1'b0, start_erase = 1'b0, abort = 1'b0;
	logic [16:0] user_addr = 17'h00000, erase_last = 17'h00006;
	logic [7:0]  user_data = 8'h00, pf = 8'h00;
	wire         busy, done, fail, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n, program_supply_high;
	wire  [16:0] fl_addr;
	wire  [7:0]  fl_dq_out, fl_dq_in;
	wire  [2:0]  mode;
	int          np, failures = 0, comparisons = 0, cyc = 0;
	always #20 mclk = ~mclk;
	fpvs_seq #(.ERASE_CYC(50)) dut (.mclk, .reset, .start_prog, .start_erase, .abort, .user_addr, .user_data,
		.erase_last, .busy, .done, .fail, .fl_addr, .fl_dq_out, .fl_dq_oe_n, .fl_dq_in, .fl_ce_n, .fl_oe_n,
		.fl_we_n, .program_supply_high);
	fpvs_flash_model fm (.fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_oe_n, .program_supply_high, .fl_addr,
		.fl_dq_out, .pf, .ef(pf), .fl_dq_in, .np, .mode);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %0h want %0h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Start a job, abort after abt cycles if asked, await done
	task run(input logic prog, input logic [16:0] a, input logic [7:0] d, input logic [7:0] p, input int abt);
		int n;
		n = 0;
		user_addr <= a;
		user_data <= d;
		pf <= p;
		start_prog <= prog;
		start_erase <= !prog;
		@(posedge mclk);
		start_prog <= 1'b0;
		start_erase <= 1'b0;
		while (done !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
			if (n == abt) abort <= 1'b1;
		end
		abort <= 1'b0;
		@(posedge mclk);
		check(n < 20000, 1);
		check(mode, 0);
		check({busy, fl_ce_n, program_supply_high}, 3'h2);
	endtask
	// First pulse verifies
	task t_first;
		run(1'b1, 17'h00005, 8'hA5, 8'h00, 0);
		check(fail, 0);
		check(np, 1);
		check(fm.mem[5], 8'hA5);
	endtask
	// Two weak pulses force retries
	task t_retry;
		run(1'b1, 17'h00006, 8'h3C, 8'h02, 0);
		check(np, 3);
		check(fm.mem[6], 8'h3C);
	endtask
	// A byte that never verifies stops at the limit
	task t_limit;
		run(1'b1, 17'h00007, 8'h00, 8'h1E, 0);
		check(fail, 1);
		check(np, 25);
	endtask
	// Interrupt service ends the job early
	task t_abort;
		run(1'b1, 17'h00008, 8'h00, 8'h1E, 100);
		check(fail, 1);
	endtask
	// Erase repeats until programmed bytes read erased
	task t_erase;
		run(1'b0, 17'h00000, 8'h00, 8'h02, 0);
		check(fail, 0);
		check(np, 3);
		for (int i = 0; i < 7; i++)
			check(fm.mem[i], 8'hFF);
		check(fm.nmask, 1);
	endtask
	// Reset in mid-pulse drops strobes, status and supply
	task t_reset;
		start_prog <= 1'b1;
		@(posedge mclk);
		start_prog <= 1'b0;
		repeat (50) @(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		check({busy, fail, fl_we_n, fl_ce_n, program_supply_high}, 5'h06);
		reset <= 1'b0;
		@(posedge mclk);
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			summarize;
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		t_first;
		t_retry;
		t_limit;
		t_abort;
		t_reset;
		t_erase;
		summarize;
	end
endmodule
`default_nettype wire
